/* charge_sel_pkg.sv */
// Constants for the temperature-banded charge selector
package charge_sel_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_LOW_CUTOFF = 8'h00;
  localparam logic [7:0] IDX_COOL_TOP = 8'h01;
  localparam logic [7:0] IDX_NORMAL_TOP = 8'h02;
  localparam logic [7:0] IDX_WARM_TOP = 8'h03;
  localparam logic [7:0] IDX_HIGH_CUTOFF = 8'h04;
  localparam logic [7:0] IDX_HYST = 8'h05;
  localparam logic [7:0] IDX_B1_VOLT = 8'h06;
  localparam logic [7:0] IDX_B2_VOLT = 8'h08;
  localparam logic [7:0] IDX_B3_VOLT = 8'h0a;
  localparam logic [7:0] IDX_B4_VOLT = 8'h0c;
  localparam logic [7:0] IDX_B1_CUR = 8'h0e;
  localparam logic [7:0] IDX_B2_CUR = 8'h0f;
  localparam logic [7:0] IDX_B3_CUR = 8'h10;
  localparam logic [7:0] IDX_B4_CUR = 8'h11;
  localparam logic [7:0] IDX_STATUS = 8'h20;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h21;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h22;
  localparam logic [7:0] IDX_OUTPUTS = 8'h23;
  localparam logic [7:0] IDX_CTRL = 8'h24;

  // Reset values
  localparam logic [7:0] RST_LOW_CUTOFF = 8'h00;
  localparam logic [7:0] RST_COOL_TOP = 8'h0a;
  localparam logic [7:0] RST_NORMAL_TOP = 8'h2d;
  localparam logic [7:0] RST_WARM_TOP = 8'h32;
  localparam logic [7:0] RST_HIGH_CUTOFF = 8'h3c;
  localparam logic [7:0] RST_HYST = 8'h01;
  localparam logic [15:0] RST_B1_VOLT = 16'h10fe;
  localparam logic [15:0] RST_B2_VOLT = 16'h10fe;
  localparam logic [15:0] RST_B3_VOLT = 16'h10cc;
  localparam logic [15:0] RST_B4_VOLT = 16'h109a;
  localparam logic [7:0] RST_B1_CUR = 8'h32;
  localparam logic [7:0] RST_B2_CUR = 8'h50;
  localparam logic [7:0] RST_B3_CUR = 8'h50;
  localparam logic [7:0] RST_B4_CUR = 8'h50;
  localparam logic [2:0] RST_IRQ_MASK = 3'h0;

  // Status, interrupt and output register bit positions
  localparam int BIT_SUSPEND = 0;
  localparam int BIT_INHIBIT = 1;
  localparam int BIT_BAND_CHG = 2;
  localparam int STATUS_BAND_LSB = 2;
  localparam int OUT_VOLT_LSB = 8;

  // Band codes, one-hot: bit 0 is out of range, bits 1..4 the charging bands
  typedef enum logic [4:0] {
    BAND_OFF = 5'h01,
    BAND_1 = 5'h02,
    BAND_2 = 5'h04,
    BAND_3 = 5'h08,
    BAND_4 = 5'h10
  } band_t;
endpackage

/* charge_sel.sv */
// Temperature-banded charge current and voltage selector with APB slave
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module charge_sel
  import charge_sel_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Measurement and charger state
  input wire logic [7:0] i_temp,
  input wire logic i_temp_valid,
  input wire logic i_charging,
  // Results for the host
  output logic [7:0] o_charge_current_out,
  output logic [15:0] o_charge_voltage_out,
  output logic o_suspend_flag,
  output logic o_inhibit_flag,
  output logic o_irq
);

  typedef struct packed {
    logic [7:0] low_cutoff_temp;
    logic [7:0] cool_band_top_temp;
    logic [7:0] normal_band_top_temp;
    logic [7:0] warm_band_top_temp;
    logic [7:0] high_cutoff_temp;
    logic [7:0] band_hysteresis;
    logic [15:0] band1_voltage;
    logic [15:0] band2_voltage;
    logic [15:0] band3_voltage;
    logic [15:0] band4_voltage;
    logic [7:0] band1_current_pct;
    logic [7:0] band2_current_pct;
    logic [7:0] band3_current_pct;
    logic [7:0] band4_current_pct;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic [7:0] last_temp;
    band_t band;
    logic [7:0] cur;
    logic [15:0] volt;
    logic suspend;
    logic inhibit;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } state_t;

  state_t s_q;
  state_t s_d;

  // Signed compare; thresholds are signed degrees
  function automatic logic lt(input logic [7:0] a, input logic [7:0] b);
    lt = $signed(a) < $signed(b);
  endfunction

  // Saturating signed add so offset thresholds never wrap
  function automatic logic [7:0] sadd(input logic [7:0] a,
                                      input logic [7:0] h,
                                      input logic neg);
    logic signed [9:0] r;
    r = neg ? ($signed({{2{a[7]}}, a}) - $signed({{2{h[7]}}, h}))
            : ($signed({{2{a[7]}}, a}) + $signed({{2{h[7]}}, h}));
    if (r > 10'sd127)
    begin
      sadd = 8'h7f;
    end
    else if (r < -10'sd128)
    begin
      sadd = 8'h80;
    end
    else
    begin
      sadd = r[7:0];
    end
  endfunction

  // Plain band from fixed thresholds
  function automatic band_t classify(input logic [7:0] t, input logic [7:0] t1,
                                     input logic [7:0] t2,
                                     input logic [7:0] t3,
                                     input logic [7:0] t4,
                                     input logic [7:0] t5);
    if (lt(t, t1) || lt(t5, t))
    begin
      classify = BAND_OFF;
    end
    else if (!lt(t2, t))
    begin
      classify = BAND_1;
    end
    else if (!lt(t3, t))
    begin
      classify = BAND_2;
    end
    else if (!lt(t4, t))
    begin
      classify = BAND_3;
    end
    else
    begin
      classify = BAND_4;
    end
  endfunction

  logic [9:0] widx;
  logic wr_acc;
  logic rd_acc;
  logic [7:0] t;
  logic [7:0] h;
  logic rising;
  logic falling;
  band_t raw_b;
  band_t up_b;
  band_t dn_b;
  band_t new_b;
  logic sus_c;
  logic inh_c;
  logic [2:0] ev;

  always_comb
  begin
    s_d = s_q;
    widx = i_paddr[11:2];
    wr_acc = i_psel && i_penable && i_pwrite && s_q.pready;
    rd_acc = i_psel && !i_penable && !i_pwrite;
    t = i_temp;
    h = s_q.band_hysteresis;
    rising = lt(s_q.last_temp, t);
    falling = lt(t, s_q.last_temp);
    raw_b = classify(t, s_q.low_cutoff_temp, s_q.cool_band_top_temp,
                     s_q.normal_band_top_temp, s_q.warm_band_top_temp,
                     s_q.high_cutoff_temp);
    // Warming: lower two edges pushed up
    up_b = classify(t, sadd(s_q.low_cutoff_temp, h, 1'b0),
                    sadd(s_q.cool_band_top_temp, h, 1'b0),
                    s_q.normal_band_top_temp, s_q.warm_band_top_temp,
                    s_q.high_cutoff_temp);
    // Cooling: upper three edges pulled down
    dn_b = classify(t, s_q.low_cutoff_temp, s_q.cool_band_top_temp,
                    sadd(s_q.normal_band_top_temp, h, 1'b1),
                    sadd(s_q.warm_band_top_temp, h, 1'b1),
                    sadd(s_q.high_cutoff_temp, h, 1'b1));
    // Hysteresis only holds the present band; steady temp uses raw edges
    if (rising && up_b != raw_b)
    begin
      new_b = s_q.band;
    end
    else if (falling && dn_b != raw_b)
    begin
      new_b = s_q.band;
    end
    else
    begin
      new_b = raw_b;
    end
    // Out-of-range decisions use the raw thresholds
    sus_c = i_charging && (lt(t, s_q.low_cutoff_temp) ||
                           lt(s_q.high_cutoff_temp, t));
    inh_c = !i_charging && (lt(t, s_q.low_cutoff_temp) ||
                            lt(s_q.warm_band_top_temp, t));
    ev = 3'h0;
    if (i_temp_valid)
    begin
      s_d.last_temp = t;
      s_d.band = new_b;
      s_d.suspend = sus_c;
      s_d.inhibit = inh_c;
      ev[BIT_SUSPEND] = sus_c && !s_q.suspend;
      ev[BIT_INHIBIT] = inh_c && !s_q.inhibit;
      ev[BIT_BAND_CHG] = new_b != s_q.band;
      if (sus_c || inh_c)
      begin
        s_d.cur = 8'h00;
        s_d.volt = 16'h0000;
      end
      else
      begin
        unique case (new_b)
          BAND_1:
          begin
            s_d.cur = s_q.band1_current_pct;
            s_d.volt = s_q.band1_voltage;
          end
          BAND_2:
          begin
            s_d.cur = s_q.band2_current_pct;
            s_d.volt = s_q.band2_voltage;
          end
          BAND_3:
          begin
            s_d.cur = s_q.band3_current_pct;
            s_d.volt = s_q.band3_voltage;
          end
          BAND_4:
          begin
            s_d.cur = s_q.band4_current_pct;
            s_d.volt = s_q.band4_voltage;
          end
          BAND_OFF:
          begin
            s_d.cur = 8'h00;
            s_d.volt = 16'h0000;
          end
        endcase
      end
    end
    // APB: no wait states, ready in the access cycle after setup
    s_d.pready = rd_acc || (i_psel && !i_penable);
    s_d.pslverr = 1'b0;
    if (i_psel && !i_penable)
    begin
      s_d.prdata = 32'h0000_0000;
      unique case (widx)
        {2'b00, IDX_LOW_CUTOFF}: s_d.prdata[7:0] = s_q.low_cutoff_temp;
        {2'b00, IDX_COOL_TOP}: s_d.prdata[7:0] = s_q.cool_band_top_temp;
        {2'b00, IDX_NORMAL_TOP}: s_d.prdata[7:0] = s_q.normal_band_top_temp;
        {2'b00, IDX_WARM_TOP}: s_d.prdata[7:0] = s_q.warm_band_top_temp;
        {2'b00, IDX_HIGH_CUTOFF}: s_d.prdata[7:0] = s_q.high_cutoff_temp;
        {2'b00, IDX_HYST}: s_d.prdata[7:0] = s_q.band_hysteresis;
        {2'b00, IDX_B1_VOLT}: s_d.prdata[15:0] = s_q.band1_voltage;
        {2'b00, IDX_B2_VOLT}: s_d.prdata[15:0] = s_q.band2_voltage;
        {2'b00, IDX_B3_VOLT}: s_d.prdata[15:0] = s_q.band3_voltage;
        {2'b00, IDX_B4_VOLT}: s_d.prdata[15:0] = s_q.band4_voltage;
        {2'b00, IDX_B1_CUR}: s_d.prdata[7:0] = s_q.band1_current_pct;
        {2'b00, IDX_B2_CUR}: s_d.prdata[7:0] = s_q.band2_current_pct;
        {2'b00, IDX_B3_CUR}: s_d.prdata[7:0] = s_q.band3_current_pct;
        {2'b00, IDX_B4_CUR}: s_d.prdata[7:0] = s_q.band4_current_pct;
        {2'b00, IDX_STATUS}:
          s_d.prdata[6:0] = {s_q.band, s_q.inhibit, s_q.suspend};
        {2'b00, IDX_IRQ_STAT}: s_d.prdata[2:0] = s_q.irq_stat;
        {2'b00, IDX_IRQ_MASK}: s_d.prdata[2:0] = s_q.irq_mask;
        {2'b00, IDX_OUTPUTS}: s_d.prdata[23:0] = {s_q.volt, s_q.cur};
        default: s_d.pslverr = 1'b1;
      endcase
      if (i_pwrite)
      begin
        s_d.prdata = 32'h0000_0000;
      end
    end
    if (wr_acc)
    begin
      unique case (widx)
        {2'b00, IDX_LOW_CUTOFF}: s_d.low_cutoff_temp = i_pwdata[7:0];
        {2'b00, IDX_COOL_TOP}: s_d.cool_band_top_temp = i_pwdata[7:0];
        {2'b00, IDX_NORMAL_TOP}: s_d.normal_band_top_temp = i_pwdata[7:0];
        {2'b00, IDX_WARM_TOP}: s_d.warm_band_top_temp = i_pwdata[7:0];
        {2'b00, IDX_HIGH_CUTOFF}: s_d.high_cutoff_temp = i_pwdata[7:0];
        {2'b00, IDX_HYST}: s_d.band_hysteresis = i_pwdata[7:0];
        {2'b00, IDX_B1_VOLT}: s_d.band1_voltage = i_pwdata[15:0];
        {2'b00, IDX_B2_VOLT}: s_d.band2_voltage = i_pwdata[15:0];
        {2'b00, IDX_B3_VOLT}: s_d.band3_voltage = i_pwdata[15:0];
        {2'b00, IDX_B4_VOLT}: s_d.band4_voltage = i_pwdata[15:0];
        {2'b00, IDX_B1_CUR}: s_d.band1_current_pct = i_pwdata[7:0];
        {2'b00, IDX_B2_CUR}: s_d.band2_current_pct = i_pwdata[7:0];
        {2'b00, IDX_B3_CUR}: s_d.band3_current_pct = i_pwdata[7:0];
        {2'b00, IDX_B4_CUR}: s_d.band4_current_pct = i_pwdata[7:0];
        {2'b00, IDX_IRQ_STAT}: s_d.irq_stat = s_q.irq_stat & ~i_pwdata[2:0];
        {2'b00, IDX_IRQ_MASK}: s_d.irq_mask = i_pwdata[2:0];
        default: s_d.irq_mask = s_d.irq_mask;
      endcase
    end
    // Set after clear so a same-cycle event is kept
    s_d.irq_stat = s_d.irq_stat | ev;
    s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
  end

  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      s_q <= '{low_cutoff_temp: RST_LOW_CUTOFF,
               cool_band_top_temp: RST_COOL_TOP,
               normal_band_top_temp: RST_NORMAL_TOP,
               warm_band_top_temp: RST_WARM_TOP,
               high_cutoff_temp: RST_HIGH_CUTOFF,
               band_hysteresis: RST_HYST,
               band1_voltage: RST_B1_VOLT,
               band2_voltage: RST_B2_VOLT,
               band3_voltage: RST_B3_VOLT,
               band4_voltage: RST_B4_VOLT,
               band1_current_pct: RST_B1_CUR,
               band2_current_pct: RST_B2_CUR,
               band3_current_pct: RST_B3_CUR,
               band4_current_pct: RST_B4_CUR,
               irq_mask: RST_IRQ_MASK,
               band: BAND_OFF,
               default: '0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign o_prdata = s_q.prdata;
  assign o_pready = s_q.pready;
  assign o_pslverr = s_q.pslverr;
  assign o_charge_current_out = s_q.cur;
  assign o_charge_voltage_out = s_q.volt;
  assign o_suspend_flag = s_q.suspend;
  assign o_inhibit_flag = s_q.inhibit;
  assign o_irq = s_q.irq;

endmodule

`default_nettype wire

/* charge_sel_props.sv */
// Port-level property checker for the charge selector
`timescale 1ns/1ps
`default_nettype none
module charge_sel_props (
  // Clock, reset and bus
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // Sample side and results
  input wire logic i_temp_valid,
  input wire logic i_charging,
  input wire logic [7:0] o_charge_current_out,
  input wire logic [15:0] o_charge_voltage_out,
  input wire logic o_suspend_flag,
  input wire logic o_inhibit_flag
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rstn);
  sequence setup_s;
    i_psel && !i_penable;
  endsequence
  sequence access_s;
    i_psel && i_penable && o_pready;
  endsequence
  a_ready_after_setup: assert property (setup_s |=> access_s)
    else $error("no ready in the access cycle");
  a_ready_single: assert property (access_s |=> !o_pready)
    else $error("ready held too long");
  a_err_with_ready: assert property (o_pslverr |-> o_pready)
    else $error("error without ready");
  a_susp_zero: assert property (o_suspend_flag |->
    o_charge_current_out == 8'h00 && o_charge_voltage_out == 16'h0000)
    else $error("suspend with nonzero outputs");
  a_inh_zero: assert property (o_inhibit_flag |->
    o_charge_current_out == 8'h00 && o_charge_voltage_out == 16'h0000)
    else $error("inhibit with nonzero outputs");
  a_flags_apart: assert property (!(o_suspend_flag && o_inhibit_flag))
    else $error("both flags set");
  a_susp_cause: assert property ($rose(o_suspend_flag) |->
    $past(i_temp_valid) && $past(i_charging))
    else $error("suspend without charging sample");
  a_inh_cause: assert property ($rose(o_inhibit_flag) |->
    $past(i_temp_valid) && !$past(i_charging))
    else $error("inhibit without idle sample");
  a_hold_between: assert property (!i_temp_valid |=>
    $stable(o_charge_current_out) && $stable(o_charge_voltage_out)
    && $stable(o_suspend_flag) && $stable(o_inhibit_flag))
    else $error("outputs moved without a sample");
endmodule
bind charge_sel charge_sel_props i_props (.i_mclk(i_mclk), .i_rstn(i_rstn),
  .i_psel(i_psel), .i_penable(i_penable), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .i_temp_valid(i_temp_valid),
  .i_charging(i_charging), .o_charge_current_out(o_charge_current_out),
  .o_charge_voltage_out(o_charge_voltage_out),
  .o_suspend_flag(o_suspend_flag), .o_inhibit_flag(o_inhibit_flag));
`default_nettype wire

/* temp_source.sv */
// Temperature sensor and charger-state source feeding the selector
`timescale 1ns/1ps
`default_nettype none
module temp_source (
  // Clock
  input wire logic i_mclk,
  // Sample outputs
  output logic [7:0] o_temp,
  output logic o_temp_valid,
  output logic o_charging
);
  initial
  begin
    o_temp = 8'h00;
    o_temp_valid = 1'b0;
    o_charging = 1'b0;
  end
  task automatic send(input logic [7:0] t, input logic c);
    @(posedge i_mclk);
    o_temp <= t;
    o_temp_valid <= 1'b1;
    o_charging <= c;
    @(posedge i_mclk);
    o_temp_valid <= 1'b0;
    // Stale value must not look valid
    o_temp <= ~t;
  endtask
endmodule
`default_nettype wire

/* test_temp_banded_charge_selector.sv */
// Self-checking bench for the temperature-banded charge selector
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module test_temp_banded_charge_selector;
  import charge_sel_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rstn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, perr, irq, sus, inh, tv, chg;
  logic [7:0] temp, cur;
  logic [15:0] volt;
  logic vld_q = 1'b0;
  logic [32:0] ex;
  logic [32:0] exq[$];
  logic [31:0] x = 32'h5dcf;
  int fails = 0, n_compared = 0, cyc = 0, hy = RST_HYST, pt = 0, pb = 0;
  int th[1:5] = '{RST_LOW_CUTOFF, RST_COOL_TOP, RST_NORMAL_TOP,
    RST_WARM_TOP, RST_HIGH_CUTOFF};
  int bc[1:4] = '{RST_B1_CUR, RST_B2_CUR, RST_B3_CUR, RST_B4_CUR};
  int bv[1:4] = '{RST_B1_VOLT, RST_B2_VOLT, RST_B3_VOLT, RST_B4_VOLT};
  always #2 i_mclk = ~i_mclk;
  temp_source src (.i_mclk(i_mclk), .o_temp(temp), .o_temp_valid(tv),
    .o_charging(chg));
  charge_sel i_dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(perr), .i_temp(temp), .i_temp_valid(tv), .i_charging(chg),
    .o_charge_current_out(cur), .o_charge_voltage_out(volt),
    .o_suspend_flag(sus), .o_inhibit_flag(inh), .o_irq(irq));
  function automatic logic [31:0] rnd();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic int band(int t, int a, int b, int c, int d, int e);
    if (t < a || t > e) return 0;
    if (t <= b) return 1;
    if (t <= c) return 2;
    if (t <= d) return 3;
    return 4;
  endfunction
  task automatic sample(int t, logic c);
    int p, r;
    logic s, n;
    p = band(t, th[1], th[2], th[3], th[4], th[5]);
    r = p;
    if (t > pt) r = band(t, th[1] + hy, th[2] + hy, th[3], th[4], th[5]);
    if (t < pt) r = band(t, th[1], th[2], th[3] - hy, th[4] - hy, th[5] - hy);
    pb = (r != p) ? pb : p;
    pt = t;
    s = c && (t < th[1] || t > th[5]);
    n = !c && (t < th[1] || t > th[4]);
    if (s || n || pb == 0) exq.push_back({7'h00, n, s, 24'h00_0000});
    else exq.push_back({7'h00, n, s, 16'(bv[pb]), 8'(bc[pb])});
    src.send(8'(t), c);
  endtask
  task automatic apb(logic w, logic [7:0] idx, logic [31:0] d);
    @(posedge i_mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge i_mclk);
    penable <= 1'b1;
    do @(posedge i_mclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(logic [7:0] idx, logic [32:0] e);
    exq.push_back(e);
    apb(1'b0, idx, 32'h0000_0000);
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Results are matched in order against what the drivers queued
  always @(posedge i_mclk)
  begin
    vld_q <= tv;
    cyc <= cyc + 1;
    if (vld_q || (psel && penable && pready && !pwrite))
    begin
      ex = exq.pop_front();
      if (vld_q) `CHK({7'h00, inh, sus, volt, cur}, ex)
      else `CHK({perr, prdata}, ex)
    end
    if (cyc == 5000)
    begin
      fails++;
      give_verdict();
    end
  end
  initial
  begin
    repeat (8) @(posedge i_mclk);
    i_rstn <= 1'b1;
    for (int k = 1; k <= 5; k++) rd(8'(k - 1), 33'(th[k]));
    rd(IDX_HYST, 33'(hy));
    for (int j = 1; j <= 4; j++) rd(8'(4 + 2 * j), 33'(bv[j]));
    for (int j = 1; j <= 4; j++) rd(8'(13 + j), 33'(bc[j]));
    rd(IDX_CTRL, {1'b1, 32'h0000_0000});
    hy = 3;
    apb(1'b1, IDX_HYST, 32'h0000_0003);
    bc[4] = int'(rnd() % 101);
    apb(1'b1, IDX_B4_CUR, 32'(bc[4]));
    rd(IDX_B4_CUR, 33'(bc[4]));
    // Sweep each boundary up while charging, then down while idle
    for (int t = -2; t <= 66; t++) sample(t, 1'b1);
    for (int t = 66; t >= -2; t--) sample(t, 1'b0);
    repeat (60) sample(int'(rnd() % 71) - 5, rnd() >= 32'h8000_0000);
    // Three-band profile: warm top folded onto normal top
    th[4] = th[3];
    apb(1'b1, IDX_WARM_TOP, 32'(th[4]));
    for (int t = 40; t <= 52; t++) sample(t, 1'b1);
    apb(1'b1, IDX_IRQ_MASK, 32'h0000_0007);
    sample(70, 1'b1);
    repeat (3) @(posedge i_mclk);
    `CHK(irq, 1'b1)
    apb(1'b1, IDX_IRQ_STAT, 32'h0000_0007);
    repeat (3) @(posedge i_mclk);
    `CHK(irq, 1'b0)
    apb(1'b1, IDX_IRQ_MASK, 32'h0000_0000);
    sample(25, 1'b1);
    repeat (3) @(posedge i_mclk);
    `CHK(irq, 1'b0)
    give_verdict();
  end
endmodule
`default_nettype wire
